// ==== verilog/srt_timer.sv ====
// What this block does
// - sixteen bit counter for rtc or interval
// - count clock may be 32 khz crystal
// - asynchronous mode counts pin without synchronising
// - sync mode synchronises after the prescaler
// - exactly four modes: timer, gated, sync, async
// - timer and gated modes count instruction clock
// - both counting modes take the pin clock
// - control bit 1 selects clock source
// - control bit 6 gates; ignored for external
// - sync bit picks counting mode when external
// - prescale codes divide by 1,8,64,256
// - run bit starts, clearing it stops
// - external source counts on rising pin edge
// - halt in idle bit stops during idle
module srt_timer
  import srt_pkg::*;
#(
  parameter int CNT_W = SRT_DATA_W // counter width
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [SRT_ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_pin,
  input wire logic i_lp_osc,
  input wire logic i_gate,
  input wire logic i_idle,
  output logic [15:0] o_rdata,
  output logic [CNT_W-1:0] o_count,
  output logic o_period_match
);

  // ****************************************************************
  // register state
  // ****************************************************************
  srt_ctrl_s ctrl; // control register fields
  srt_ctrl_s next_ctrl;
  logic osc_sel; // external source is the crystal
  logic next_osc_sel;
  logic [CNT_W-1:0] count; // the counter itself
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] period; // wrap value
  logic [CNT_W-1:0] next_period;
  logic [15:0] rdata; // read data, one cycle late
  logic [15:0] next_rdata;
  logic match; // registered wrap pulse
  logic next_match;

  // ****************************************************************
  // pin sampling and sync chain state
  // ****************************************************************
  logic ext_q; // last pin level for edge detect
  logic next_ext_q;
  logic tgl; // toggles once per prescaler tick in sync mode
  logic next_tgl;
  logic sync1; // first sync stage, read by sync2 only
  logic sync2; // second sync stage
  logic sync3; // delayed copy for the edge
  logic [2:0] next_sync;

  // ****************************************************************
  // decode of mode and enables
  // ****************************************************************
  srt_mode_e mode; // one of the four modes
  logic ext_src; // level of the chosen external source
  logic ext_rise; // rising edge of that source
  logic run_en; // counter allowed to advance
  logic pre_in; // tick into the prescaler
  logic pre_out; // tick out of the prescaler
  logic inc; // one increment of the counter
  logic wr_ctrl; // write strobe hits the control register
  logic wr_count; // write strobe hits the counter
  logic wr_period; // write strobe hits the period
  logic wr_cfg; // write strobe hits the config

  // mode from source, gate and sync bits
  always_comb
  begin
    case ({ctrl.cs, ctrl.cs ? ctrl.sync : ctrl.gate})
      2'b00: mode = SRT_MODE_TIMER;
      2'b01: mode = SRT_MODE_GATED;
      2'b11: mode = SRT_MODE_SYNC;
      default: mode = SRT_MODE_ASYNC;
    endcase
  end

  // crystal or pin; both are sampled as synchronous inputs
  assign ext_src = osc_sel ? i_lp_osc : i_ext_pin;
  assign ext_rise = ext_src && !ext_q;

  // idle only stops the block when asked to
  assign run_en = ctrl.run && !(ctrl.halt_idle && i_idle);

  // prescaler input per mode
  always_comb
  begin
    case (mode)
      SRT_MODE_TIMER: pre_in = run_en;
      SRT_MODE_GATED: pre_in = run_en && i_gate;
      SRT_MODE_SYNC: pre_in = run_en && ext_rise;
      default: pre_in = run_en && ext_rise;
    endcase
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // a control write restarts the divide from zero
  srt_prescaler #(
    .CNT_W(8)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_clear(wr_ctrl),
    .i_tick(pre_in),
    .i_prescale(ctrl.prescale),
    .o_tick(pre_out)
  );

  // ****************************************************************
  // sync after the prescaler
  // ****************************************************************
  // the tick becomes a toggle so no pulse is lost in the chain;
  // costs three cycles of latency in the synchronous mode only
  always_comb
  begin
    next_ext_q = ext_src;
    next_tgl = tgl ^ (pre_out && mode == SRT_MODE_SYNC);
    next_sync = {sync2, sync1, tgl};
  end

  // register only
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ext_q <= 1'b0;
      tgl <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      ext_q <= next_ext_q;
      tgl <= next_tgl;
      sync1 <= next_sync[0];
      sync2 <= next_sync[1];
      sync3 <= next_sync[2];
    end
  end

  // async mode takes the prescaler tick straight
  always_comb
  begin
    if (mode == SRT_MODE_SYNC)
      inc = sync2 ^ sync3;
    else
      inc = pre_out;
  end

  // ****************************************************************
  // register port and counter
  // ****************************************************************
  assign wr_ctrl = i_wr && (i_addr == SRT_ADDR_CTRL);
  assign wr_count = i_wr && (i_addr == SRT_ADDR_COUNT);
  assign wr_period = i_wr && (i_addr == SRT_ADDR_PERIOD);
  assign wr_cfg = i_wr && (i_addr == SRT_ADDR_CFG);

  // next register values; a count write beats an increment
  always_comb
  begin
    next_ctrl = ctrl;
    next_osc_sel = osc_sel;
    next_period = period;
    next_count = count;
    next_match = 1'b0;
    next_rdata = SRT_RDATA_RST;
    if (wr_ctrl)
    begin
      next_ctrl.run = i_wdata[SRT_BIT_RUN];
      next_ctrl.halt_idle = i_wdata[SRT_BIT_HALT_IDLE];
      next_ctrl.gate = i_wdata[SRT_BIT_GATE];
      next_ctrl.prescale = i_wdata[SRT_BIT_PS_HI:SRT_BIT_PS_LO];
      next_ctrl.sync = i_wdata[SRT_BIT_SYNC];
      next_ctrl.cs = i_wdata[SRT_BIT_CS];
    end
    if (wr_cfg)
      next_osc_sel = i_wdata[SRT_BIT_OSC];
    if (wr_period)
      next_period = i_wdata[CNT_W-1:0];
    if (wr_count)
      next_count = i_wdata[CNT_W-1:0];
    else if (inc && count == period)
    begin
      // wrap at the period; full range by default
      next_count = '0;
      next_match = 1'b1;
    end
    else if (inc)
      next_count = count + CNT_W'(1);
    if (i_rd)
    begin
      // unused bits and unmapped addresses read as zero
      case (i_addr)
        SRT_ADDR_CTRL:
        begin
          next_rdata[SRT_BIT_RUN] = ctrl.run;
          next_rdata[SRT_BIT_HALT_IDLE] = ctrl.halt_idle;
          next_rdata[SRT_BIT_GATE] = ctrl.gate;
          next_rdata[SRT_BIT_PS_HI:SRT_BIT_PS_LO] = ctrl.prescale;
          next_rdata[SRT_BIT_SYNC] = ctrl.sync;
          next_rdata[SRT_BIT_CS] = ctrl.cs;
        end
        SRT_ADDR_COUNT: next_rdata[CNT_W-1:0] = count;
        SRT_ADDR_PERIOD: next_rdata[CNT_W-1:0] = period;
        SRT_ADDR_CFG: next_rdata[SRT_BIT_OSC] = osc_sel;
        default: next_rdata = SRT_RDATA_RST;
      endcase
    end
  end

  // register only
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl <= '0;
      osc_sel <= 1'b0;
      period <= CNT_W'(SRT_PERIOD_RST);
      count <= CNT_W'(SRT_COUNT_RST);
      match <= 1'b0;
      rdata <= SRT_RDATA_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      osc_sel <= next_osc_sel;
      period <= next_period;
      count <= next_count;
      match <= next_match;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
  assign o_count = count;
  assign o_period_match = match;

  // ****************************************************************
  // checks
  // ****************************************************************
  // a prescaler tick handed to the sync chain in the sync mode
  sequence sync_tick_s;
    mode == SRT_MODE_SYNC && pre_out && !wr_ctrl;
  endsequence

  // the counter steps one on the fourth edge
  sequence sync_inc_s;
    ##SRT_SYNC_LAT inc;
  endsequence

  sync_latency_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    sync_tick_s |-> sync_inc_s)
    else $error("synchronised tick did not arrive three cycles later");

  async_direct_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (mode == SRT_MODE_ASYNC && pre_out) |-> inc)
    else $error("async tick was delayed");

  run_stop_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (!ctrl.run && !wr_count && mode != SRT_MODE_SYNC) |=>
      $stable(count))
    else $error("counter moved while stopped");

  gate_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (mode == SRT_MODE_GATED && !i_gate) |-> !pre_in)
    else $error("gated timer counted with gate low");

  // gate high at 1:1 must step on every such cycle
  gated_step_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (mode == SRT_MODE_GATED && run_en && i_gate && !i_wr
     && ctrl.prescale == SRT_PS_DIV1 && count != period) |=>
      count == $past(count) + CNT_W'(1))
    else $error("gated timer at 1:1 missed a gate high cycle");

  timer_step_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (mode == SRT_MODE_TIMER && run_en && ctrl.prescale == SRT_PS_DIV1
     && !i_wr && count != period) |=>
      count == $past(count) + CNT_W'(1))
    else $error("timer at 1:1 did not step every cycle");

  // 1:1 adds no cycle between a tick and its output
  div1_pass_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl.prescale == SRT_PS_DIV1) |-> (pre_out == pre_in))
    else $error("prescaler at 1:1 did not pass the tick");

  ext_edge_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl.cs && run_en) |-> (pre_in == ext_rise))
    else $error("external tick not tied to a rising edge");

  // judged from the pin itself, so a broken edge detector shows up;
  // a source switch in the last cycle leaves the old level behind
  pin_rise_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl.cs && run_en && !osc_sel && !$past(osc_sel)) |->
      (pre_in == (i_ext_pin && !$past(i_ext_pin))))
    else $error("pin tick not tied to a rising pin level change");

  idle_halt_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl.halt_idle && i_idle) |-> !pre_in)
    else $error("prescaler fed while halted in idle");

  // halted in idle, the counter itself must hold as well
  idle_stop_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (ctrl.halt_idle && i_idle && !wr_count && mode != SRT_MODE_SYNC)
      |=> $stable(count))
    else $error("counter moved while halted in idle");

  read_late_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_addr == SRT_ADDR_PERIOD) |=>
      o_rdata[CNT_W-1:0] == $past(period))
    else $error("period read back wrong");

  // control fields read back one cycle after the strobe
  ctrl_read_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_addr == SRT_ADDR_CTRL) |=>
      (o_rdata[SRT_BIT_CS] == $past(ctrl.cs)
       && o_rdata[SRT_BIT_GATE] == $past(ctrl.gate)))
    else $error("control bits read back wrong");

  // a count write beats an increment in the same cycle
  count_write_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    wr_count |=> (count == $past(i_wdata[CNT_W-1:0])))
    else $error("count write did not land");

  wrap_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (inc && !wr_count && count == period) |=>
      (count == '0 && o_period_match))
    else $error("counter did not wrap at period");

endmodule // srt_timer

// ==== verilog/srt_pkg.sv ====
// ****************************************************************
// shared constants and types of the sixteen bit timer
// ****************************************************************
package srt_pkg;

  // ****************************************************************
  // widths and clock figures
  // ****************************************************************
  localparam int SRT_DATA_W = 16; // counter and register width
  localparam int SRT_ADDR_W = 4; // register port address width
  localparam int SRT_FCY_HZ = 40000000; // instruction clock rate
  localparam int SRT_LP_OSC_HZ = 32768; // low power crystal rate
  localparam int SRT_SYNC_LAT = 3; // cycles, prescaler tick to count

  // ****************************************************************
  // register indices on the plain port
  // ****************************************************************
  localparam logic [3:0] SRT_ADDR_CTRL = 4'h0; // control register
  localparam logic [3:0] SRT_ADDR_COUNT = 4'h1; // live count
  localparam logic [3:0] SRT_ADDR_PERIOD = 4'h2; // wrap value
  localparam logic [3:0] SRT_ADDR_CFG = 4'h3; // source config

  // ****************************************************************
  // field positions of the control and config registers
  // ****************************************************************
  localparam int SRT_BIT_RUN = 15; // counter run bit
  localparam int SRT_BIT_HALT_IDLE = 13; // halt in idle bit
  localparam int SRT_BIT_GATE = 6; // gated accumulation enable
  localparam int SRT_BIT_PS_HI = 5; // prescale select, high bit
  localparam int SRT_BIT_PS_LO = 4; // prescale select, low bit
  localparam int SRT_BIT_SYNC = 2; // external clock sync select
  localparam int SRT_BIT_CS = 1; // clock source select
  localparam int SRT_BIT_OSC = 0; // cfg: take the 32 khz crystal

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [15:0] SRT_COUNT_RST = 16'h0000; // counter
  localparam logic [15:0] SRT_PERIOD_RST = 16'hffff; // full range
  localparam logic [15:0] SRT_RDATA_RST = 16'h0000; // read data

  // ****************************************************************
  // prescale codes and their terminal counts
  // ****************************************************************
  localparam logic [1:0] SRT_PS_DIV1 = 2'b00; // 1:1
  localparam logic [1:0] SRT_PS_DIV8 = 2'b01; // 1:8
  localparam logic [1:0] SRT_PS_DIV64 = 2'b10; // 1:64
  localparam logic [1:0] SRT_PS_DIV256 = 2'b11; // 1:256
  localparam logic [7:0] SRT_TERM_DIV1 = 8'h00; // ticks minus one
  localparam logic [7:0] SRT_TERM_DIV8 = 8'h07;
  localparam logic [7:0] SRT_TERM_DIV64 = 8'h3f;
  localparam logic [7:0] SRT_TERM_DIV256 = 8'hff;

  // ****************************************************************
  // operating modes and control fields
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SRT_MODE_TIMER = 2'b00, // internal clock, free
    SRT_MODE_GATED = 2'b01, // internal clock while gate high
    SRT_MODE_SYNC = 2'b10, // pin clock, synced after prescaler
    SRT_MODE_ASYNC = 2'b11 // pin clock, no sync
  } srt_mode_e;

  typedef struct packed
  {
    logic run; // counter on
    logic halt_idle; // stop while device idles
    logic gate; // gated accumulation
    logic [1:0] prescale; // divide select
    logic sync; // sync external clock
    logic cs; // external clock source
  } srt_ctrl_s;

endpackage

// ==== verilog/srt_prescaler.sv ====
// ****************************************************************
// input clock prescaler: 1, 8, 64 or 256 ticks per output tick
// ****************************************************************
module srt_prescaler
  import srt_pkg::*;
#(
  parameter int CNT_W = 8 // wide enough for the largest divide
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [1:0] i_prescale,
  output logic o_tick
);

  logic [CNT_W-1:0] cnt; // ticks seen in this period
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] term; // last count before wrap

  // terminal count from the divide code
  always_comb
  begin
    case (i_prescale)
      SRT_PS_DIV1: term = CNT_W'(SRT_TERM_DIV1);
      SRT_PS_DIV8: term = CNT_W'(SRT_TERM_DIV8);
      SRT_PS_DIV64: term = CNT_W'(SRT_TERM_DIV64);
      default: term = CNT_W'(SRT_TERM_DIV256);
    endcase
  end

  // output tick is combinational so 1:1 adds no latency
  assign o_tick = i_tick && (cnt >= term);

  // next count; a clear drops a partial period
  always_comb
  begin
    next_cnt = cnt;
    if (i_clear)
      next_cnt = '0;
    else if (o_tick)
      next_cnt = '0;
    else if (i_tick)
      next_cnt = cnt + CNT_W'(1);
  end

  // register only
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // one output per terminal-count input tick
  div_wrap_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (o_tick && !i_clear) |=> (cnt == '0))
    else $error("prescaler did not wrap after its output tick");

endmodule // srt_prescaler

// ==== tb/srt_ext_src.sv ====
// ****************************************************************
// far side model: pulse source on a count pin
// ****************************************************************
module srt_ext_src
(
  input wire logic i_clk,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pin rests low between bursts, like a gated source
  initial o_pin = 1'b0;

  // ****************************************************************
  // burst of rising edges, half period in clock cycles
  // ****************************************************************
  // a long half period models a slow crystal, a short one a fast pin
  task automatic burst(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (half) @(posedge i_clk);
      o_pin <= 1'b0;
    end
  endtask

endmodule // srt_ext_src

// ==== tb/test_srt_timer.sv ====
// ****************************************************************
// self checking bench of the sixteen bit timer
// ****************************************************************
module test_srt_timer
  import srt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0; // 40 mhz system clock
  logic i_nrst = 1'b0; // held low at start
  logic [SRT_ADDR_W-1:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_gate = 1'b0; // gate level for gated mode
  logic i_idle = 1'b0; // device idle flag
  logic ext_pin; // driven by the pin source model
  logic lp_osc; // driven by the crystal model
  logic [15:0] o_rdata;
  logic [15:0] o_count;
  logic o_period_match;
  int errors = 0;
  int n_checks = 0;
  int n_match = 0; // wrap pulses seen
  logic [15:0] d; // last read word

  // control words built from the package field positions
  localparam logic [15:0] C_RUN = 16'h0001 << SRT_BIT_RUN;
  localparam logic [15:0] C_HALT = 16'h0001 << SRT_BIT_HALT_IDLE;
  localparam logic [15:0] C_GATE = 16'h0001 << SRT_BIT_GATE;
  localparam logic [15:0] C_SYNC = 16'h0001 << SRT_BIT_SYNC;
  localparam logic [15:0] C_CS = 16'h0001 << SRT_BIT_CS;

  // ****************************************************************
  // clock, design and far side
  // ****************************************************************
  always #12.5 i_clk = ~i_clk;

  srt_timer srt_timer_inst
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_ext_pin(ext_pin),
    .i_lp_osc(lp_osc),
    .i_gate(i_gate),
    .i_idle(i_idle),
    .o_rdata(o_rdata),
    .o_count(o_count),
    .o_period_match(o_period_match)
  );

  srt_ext_src ext_src_inst (.i_clk(i_clk), .o_pin(ext_pin));
  srt_ext_src osc_src_inst (.i_clk(i_clk), .o_pin(lp_osc));

  // wrap pulse counter, looked at mid cycle where the pulse stands
  always @(negedge i_clk)
  begin
    if (o_period_match === 1'b1)
    begin
      n_match++;
    end
  end

  // ****************************************************************
  // shared tasks: bus cycles, compare, verdict
  // ****************************************************************
  // every bus task is entered just after a rising edge; a write lets
  // one more edge pass so two writes never touch the strobe at once
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // data stand only in the cycle after the strobe: sampled mid cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
    @(posedge i_clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // run for exactly k edges from the run write, stop, read the count
  task automatic run_for(input logic [15:0] c, input int k,
                         output logic [15:0] v);
    wr(SRT_ADDR_COUNT, 16'h0000);
    wr(SRT_ADDR_CTRL, c);
    repeat (k - 2) @(posedge i_clk);
    wr(SRT_ADDR_CTRL, 16'h0000);
    // a stopped counter must hold through this wait
    repeat (10) @(posedge i_clk);
    rd(SRT_ADDR_COUNT, v);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(SRT_ADDR_CTRL, d);
    chk("ctrl", d, 16'h0000);
    rd(SRT_ADDR_COUNT, d);
    chk("count", d, SRT_COUNT_RST);
    rd(SRT_ADDR_PERIOD, d);
    chk("period", d, SRT_PERIOD_RST);
    rd(SRT_ADDR_CFG, d);
    chk("cfg", d, 16'h0000);
    $display("done reset values");
  endtask

  // unused bits read 0, unmapped place swallows writes
  task automatic t_bits();
    wr(SRT_ADDR_CTRL, 16'hffff);
    rd(SRT_ADDR_CTRL, d);
    chk("ctrl bits", d, 16'ha076);
    wr(SRT_ADDR_CTRL, 16'h0000);
    wr(4'h9, 16'h1234);
    rd(4'h9, d);
    chk("unmapped", d, 16'h0000);
    rd(SRT_ADDR_CTRL, d);
    chk("ctrl kept", d, 16'h0000);
    $display("done register bits");
  endtask

  // every prescale code; spans of the 1:8 and slower codes leave slack of half a divide
  task automatic t_prescale();
    int k[4] = '{20, 44, 224, 640};
    logic [15:0] e[4] = '{16'h0014, 16'h0005, 16'h0003, 16'h0002};
    for (int i = 0; i < 4; i++)
    begin
      run_for(C_RUN | (16'(i) << SRT_BIT_PS_LO), k[i], d);
      chk("prescaled count", d, e[i]);
    end
    $display("done prescale");
  endtask

  // only cycles with the gate high may count
  task automatic t_gated();
    wr(SRT_ADDR_COUNT, 16'h0000);
    wr(SRT_ADDR_CTRL, C_RUN | C_GATE);
    repeat (4) @(posedge i_clk);
    i_gate <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_gate <= 1'b0;
    repeat (5) @(posedge i_clk);
    wr(SRT_ADDR_CTRL, 16'h0000);
    rd(SRT_ADDR_COUNT, d);
    chk("gated count", d, 16'h000a);
    $display("done gated");
  endtask

  // pin and crystal bursts side by side; only the chosen one counts
  task automatic ext_case(input logic [15:0] c, input logic [15:0] cf,
                          input int na, input int nb,
                          input logic [15:0] e);
    wr(SRT_ADDR_CFG, cf);
    wr(SRT_ADDR_COUNT, 16'h0000);
    wr(SRT_ADDR_CTRL, c);
    fork
      ext_src_inst.burst(na, 2);
      osc_src_inst.burst(nb, 3);
    join
    // room for the sync chain before stopping
    repeat (10) @(posedge i_clk);
    wr(SRT_ADDR_CTRL, 16'h0000);
    rd(SRT_ADDR_COUNT, d);
    chk("external count", d, e);
  endtask

  task automatic t_ext();
    // gate bit set with gate low must not matter here
    ext_case(C_RUN | C_CS | C_SYNC | C_GATE, 16'h0000, 6, 0,
             16'h0006);
    ext_case(C_RUN | C_CS, 16'h0000, 6, 0, 16'h0006);
    ext_case(C_RUN | C_CS | 16'h0010, 16'h0000, 16, 0,
             16'h0002);
    ext_case(C_RUN | C_CS, 16'h0001, 3, 5, 16'h0005);
    wr(SRT_ADDR_CFG, 16'h0000);
    $display("done external");
  endtask

  // halt in idle stops counting while the device idles; idle alone does not
  task automatic t_idle();
    i_idle <= 1'b1;
    run_for(C_RUN | C_HALT, 20, d);
    chk("halted count", d, 16'h0000);
    run_for(C_RUN, 20, d);
    chk("idle count", d, 16'h0014);
    i_idle <= 1'b0;
    $display("done idle");
  endtask

  // short period: 13 increments over a 0..4 range wrap twice
  task automatic t_wrap();
    wr(SRT_ADDR_PERIOD, 16'h0004);
    n_match = 0;
    run_for(C_RUN, 13, d);
    chk("wrapped count", d, 16'h0003);
    chk("live count", o_count, 16'h0003);
    chk("wrap pulses", 16'(n_match), 16'h0002);
    wr(SRT_ADDR_PERIOD, 16'hffff);
    $display("done wrap");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_bits();
    t_prescale();
    t_gated();
    t_ext();
    t_idle();
    t_wrap();
    close_out();
  end

  // tests need about 1400 cycles; this is over fourteen times that
  initial
  begin
    #(25 * 20000);
    errors++;
    close_out();
  end

endmodule // test_srt_timer
